// *** include/odsip_pkg.sv ***
// Purpose: shared constants and types of the octal converter serial input port
// Assumes: 16-bit serial words, eight 12-bit channels, 32-bit register bus
// Notes:   register offsets, field positions and word constants live here
package odsip_pkg;

	// ------------------------------------------------------------
	// serial word layout
	// ------------------------------------------------------------
	localparam int          ODSIP_WORD_W     = 16;
	localparam int          ODSIP_DATA_W     = 12;
	localparam int          ODSIP_ADDR_W     = 4;
	localparam int          ODSIP_NUM_CH     = 8;
	localparam int          ODSIP_CNT_W      = 4;
	localparam logic [3:0]  ODSIP_CNT_FIRST  = 4'h1;
	localparam logic [3:0]  ODSIP_CNT_LAST   = 4'hF;
	localparam logic [3:0]  ODSIP_A_CTRL0    = 4'h8;
	localparam logic [3:0]  ODSIP_A_CTRL1    = 4'h9;
	localparam logic [3:0]  ODSIP_A_PRESET   = 4'hA;
	localparam logic [1:0]  ODSIP_PAIR_TAG   = 2'h3;
	localparam int          ODSIP_CHAIN_BIT  = 3;
	localparam logic [11:0] ODSIP_CODE_ZERO  = 12'h000;

	// ------------------------------------------------------------
	// register bus map
	// ------------------------------------------------------------
	localparam int          ODSIP_AXI_AW     = 8;
	localparam logic [7:0]  ODSIP_OFF_CTRL   = 8'h00;
	localparam logic [7:0]  ODSIP_OFF_STAT   = 8'h04;
	localparam logic [7:0]  ODSIP_OFF_CFG0   = 8'h08;
	localparam logic [7:0]  ODSIP_OFF_CFG1   = 8'h0C;
	localparam logic [7:0]  ODSIP_OFF_PRE    = 8'h10;
	localparam logic [2:0]  ODSIP_WIN_LATCH  = 3'h1;
	localparam logic [2:0]  ODSIP_WIN_HOLD   = 3'h2;
	localparam int          ODSIP_STAT_MODE  = 0;
	localparam int          ODSIP_STAT_LOAD  = 1;
	localparam int          ODSIP_STAT_PRE   = 2;
	localparam int          ODSIP_STAT_PEND  = 3;
	localparam logic [1:0]  ODSIP_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  ODSIP_RESP_SLVERR = 2'h2;
	localparam logic [31:0] ODSIP_ZERO32     = 32'h0000_0000;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef logic [ODSIP_NUM_CH-1:0][ODSIP_DATA_W-1:0] odsip_chan_t;

	typedef struct packed {
		logic [ODSIP_ADDR_W-1:0] addr;
		logic [ODSIP_DATA_W-1:0] data;
	} odsip_word_t;

endpackage

// *** src/odsip_sync.sv ***
// Purpose: two-flop level synchroniser, one bit per lane
// Assumes: inputs are levels that stay put for several destination clocks
// Notes:   first stage feeds only the second stage
module odsip_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_resetn,
	// lanes
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			stage1 <= '0;
			o_sync <= '0;
		end
		else
		begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end

endmodule

// *** src/odsip_top.sv ***
// Purpose: serial input port of an eight channel 12-bit converter
// Assumes: host shifts words on i_shift_clock, registers reached over AXI4-Lite
// Notes:   link logic runs on the falling shift clock, the rest on i_core_clk
//
// Notes on behaviour
// - falling frame_sync starts a word; bits captured on falling shift edges, MSB first
// - last bit of a word is captured on the 16th falling edge after start
// - after 16 bits the word is copied into the holding register it addresses
// - holding registers reach output latches only while load_outputs_n is low
// - load_outputs_n is asynchronous; tied low, each word updates at once
// - serial_out repeats serial_in delayed by exactly 16 shift clock cycles
// - mode strap high selects held_frame_mode, low selects pulse_frame_mode
// - held_frame_mode: frame_sync rising before 16th edge discards the word
// - held_frame_mode: word committed only after frame_sync returns high
// - pulse_frame_mode: frame_sync may rise early, word still completes
// - power-on reset clears holding registers and output latches to zero
// - each channel code is 12 bits, 0x000 to 0xFFF, straight to the output
// - word carries 4-bit target address on top, 12-bit data below
// - serial_out forwards data only while chain enable in CTRL0 is set
// - pair addresses load one channel and its partner with the complement
// - preset_n low forces every output to the preset register value
module odsip_top
	import odsip_pkg::*;
(
	// core clock and reset
	input  wire logic                         i_core_clk,
	input  wire logic                         i_resetn,
	// serial link
	input  wire logic                         i_shift_clock,
	input  wire logic                         i_frame_sync,
	input  wire logic                         i_serial_in,
	output logic                              o_serial_out,
	// static and asynchronous pins
	input  wire logic                         i_mode_strap,
	input  wire logic                         i_load_outputs_n,
	input  wire logic                         i_preset_n,
	// channel codes
	output odsip_pkg::odsip_chan_t            o_channel_code,
	// axi4-lite write
	input  wire logic [odsip_pkg::ODSIP_AXI_AW-1:0] i_axi_awaddr,
	input  wire logic                         i_axi_awvalid,
	output logic                              o_axi_awready,
	input  wire logic [31:0]                  i_axi_wdata,
	input  wire logic [3:0]                   i_axi_wstrb,
	input  wire logic                         i_axi_wvalid,
	output logic                              o_axi_wready,
	output logic [1:0]                        o_axi_bresp,
	output logic                              o_axi_bvalid,
	input  wire logic                         i_axi_bready,
	// axi4-lite read
	input  wire logic [odsip_pkg::ODSIP_AXI_AW-1:0] i_axi_araddr,
	input  wire logic                         i_axi_arvalid,
	output logic                              o_axi_arready,
	output logic [31:0]                       o_axi_rdata,
	output logic [1:0]                        o_axi_rresp,
	output logic                              o_axi_rvalid,
	input  wire logic                         i_axi_rready
);

	// ------------------------------------------------------------
	// link domain
	// ------------------------------------------------------------
	logic                    armed;
	logic                    active;
	logic [ODSIP_CNT_W-1:0]  bit_cnt;
	logic [ODSIP_WORD_W-1:0] delay_line;
	odsip_word_t             link_word;
	logic                    word_tgl;
	logic [1:0]              link_sync;
	logic                    chain_l;
	logic                    held_l;
	logic                    mode_held;
	logic [ODSIP_DATA_W-1:0] cfg0;

	wire start_bit = armed & ~i_frame_sync;
	wire abort_bit = active & i_frame_sync & held_l;
	wire last_bit  = active & (bit_cnt == ODSIP_CNT_LAST);

	odsip_sync #(.WIDTH(2)) u_link_sync (
		.i_clk    (~i_shift_clock),
		.i_resetn (i_resetn),
		.i_async  ({cfg0[ODSIP_CHAIN_BIT], mode_held}),
		.o_sync   (link_sync)
	);
	assign chain_l = link_sync[1];
	assign held_l  = link_sync[0];

	// armed is set by frame_sync itself, so a stopped shift clock never hides a start
	always_ff @(negedge i_shift_clock or posedge i_frame_sync or negedge i_resetn)
	begin
		if (!i_resetn)
			armed <= 1'b1;
		else if (i_frame_sync)
			armed <= 1'b1;
		else if (start_bit)
			armed <= 1'b0;
	end

	always_ff @(negedge i_shift_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			active  <= 1'b0;
			bit_cnt <= '0;
		end
		else if (start_bit)
		begin
			active  <= 1'b1;
			bit_cnt <= ODSIP_CNT_FIRST;
		end
		else if (abort_bit)
			active  <= 1'b0;
		else if (active)
		begin
			bit_cnt <= bit_cnt + ODSIP_CNT_FIRST;
			if (last_bit)
				active <= 1'b0;
		end
	end

	// the delay line doubles as the shift register, msb arrives first
	always_ff @(negedge i_shift_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			delay_line   <= '0;
			o_serial_out <= 1'b0;
			link_word    <= '0;
			word_tgl     <= 1'b0;
		end
		else
		begin
			delay_line   <= {delay_line[ODSIP_WORD_W-2:0], i_serial_in};
			o_serial_out <= chain_l & delay_line[ODSIP_WORD_W-1];
			if (last_bit && !abort_bit && !start_bit)
			begin
				link_word <= {delay_line[ODSIP_WORD_W-2:0], i_serial_in};
				word_tgl  <= ~word_tgl;
			end
		end
	end

	a_chain_delay: assert property (@(negedge i_shift_clock) disable iff (!i_resetn)
		chain_l && $past(chain_l) |-> o_serial_out == $past(i_serial_in, 17))
		else $error("serial_out is not serial_in delayed by 16");
	a_chain_off: assert property (@(negedge i_shift_clock) disable iff (!i_resetn)
		!chain_l |=> !o_serial_out)
		else $error("serial_out forwards data while chain is off");
	a_sixteen_bits: assert property (@(negedge i_shift_clock) disable iff (!i_resetn)
		$changed(word_tgl) |-> $past(active) && $past(bit_cnt) == ODSIP_CNT_LAST)
		else $error("word completed on the wrong edge");
	a_abort_drop: assert property (@(negedge i_shift_clock) disable iff (!i_resetn)
		abort_bit && !start_bit |=> !active && $stable(word_tgl))
		else $error("aborted word was not discarded");

	// ------------------------------------------------------------
	// core domain: crossing and commit
	// ------------------------------------------------------------
	logic [4:0]  core_sync;
	logic        tgl_seen;
	logic        strap_taken;
	logic [1:0]  strap_age;
	logic        pending;
	logic        rx_enable;
	odsip_word_t core_word;
	odsip_chan_t holding;
	logic [ODSIP_DATA_W-1:0] cfg1;
	logic [ODSIP_DATA_W-1:0] preset;

	odsip_sync #(.WIDTH(5)) u_core_sync (
		.i_clk    (i_core_clk),
		.i_resetn (i_resetn),
		.i_async  ({word_tgl, i_frame_sync, i_mode_strap, i_preset_n, i_load_outputs_n}),
		.o_sync   (core_sync)
	);
	wire tgl_s     = core_sync[4];
	wire fs_high_s = core_sync[3];
	wire mode_s    = core_sync[2];
	wire preset_s  = core_sync[1];
	wire load_s    = core_sync[0];

	wire new_word  = tgl_s ^ tgl_seen;
	wire commit    = pending & rx_enable & (~mode_held | fs_high_s);
	wire is_chan   = ~core_word.addr[ODSIP_ADDR_W-1];
	wire is_pair   = core_word.addr[3:2] == ODSIP_PAIR_TAG;
	wire [2:0] pair_lo = {core_word.addr[1:0], 1'b0};
	wire [2:0] pair_hi = {core_word.addr[1:0], 1'b1};

	// a word is only latched while its source register is stable; words closer
	// than about three core cycles overrun this crossing
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			tgl_seen    <= 1'b0;
			pending     <= 1'b0;
			core_word   <= '0;
			strap_taken <= 1'b0;
			strap_age   <= '0;
			mode_held   <= 1'b0;
		end
		else
		begin
			tgl_seen <= tgl_s;
			if (new_word)
			begin
				core_word <= link_word;
				pending   <= 1'b1;
			end
			else if (commit)
				pending <= 1'b0;
			// the strap synchroniser holds the pin only two edges after release
			strap_age <= {strap_age[0], 1'b1};
			if (strap_age[1] && !strap_taken)
			begin
				strap_taken <= 1'b1;
				mode_held   <= mode_s;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			holding <= '0;
			cfg0    <= '0;
			cfg1    <= '0;
			preset  <= '0;
		end
		else if (commit)
		begin
			if (is_chan)
				holding[core_word.addr[2:0]] <= core_word.data;
			else if (is_pair)
			begin
				holding[pair_lo] <= core_word.data;
				holding[pair_hi] <= ~core_word.data;
			end
			else if (core_word.addr == ODSIP_A_CTRL0)
				cfg0 <= core_word.data;
			else if (core_word.addr == ODSIP_A_CTRL1)
				cfg1 <= core_word.data;
			else if (core_word.addr == ODSIP_A_PRESET)
				preset <= core_word.data;
		end
	end

	// output latches; preset wins over a load
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_channel_code <= '0;
		else if (!preset_s)
			o_channel_code <= {ODSIP_NUM_CH{preset}};
		else if (!load_s)
			o_channel_code <= holding;
	end

	a_commit_clear: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		commit && !new_word |=> !pending)
		else $error("pending word not cleared after commit");
	a_holding_load: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		commit && is_chan |=> holding[$past(core_word.addr[2:0])] == $past(core_word.data))
		else $error("holding register not loaded");
	a_pair_compl: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		commit && is_pair |=> holding[$past(pair_hi)] == ~holding[$past(pair_lo)])
		else $error("pair partner is not the complement");
	a_held_wait: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		pending && mode_held && !fs_high_s |=> $stable(holding))
		else $error("held mode committed before frame_sync rose");
	a_latch_load: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		preset_s && !load_s |=> o_channel_code == $past(holding))
		else $error("latches did not follow holding registers");
	a_latch_hold: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		preset_s && load_s |=> $stable(o_channel_code))
		else $error("latches changed while load is high");
	a_preset_force: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		!preset_s |=> o_channel_code == {ODSIP_NUM_CH{$past(preset)}})
		else $error("preset not forced onto outputs");

	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	logic [ODSIP_AXI_AW-1:0] aw_addr;
	logic [31:0]             w_data;
	logic [3:0]              w_strb;
	logic [31:0]             rd_data;
	logic                    rd_err;
	logic                    wr_armed;

	wire aw_take  = i_axi_awvalid & o_axi_awready;
	wire w_take   = i_axi_wvalid & o_axi_wready;
	// armed only once readies were offered, so the idle state after reset answers nothing
	wire wr_fire  = wr_armed & ~o_axi_awready & ~o_axi_wready & ~o_axi_bvalid;
	wire wr_ctrl  = aw_addr == ODSIP_OFF_CTRL;
	wire wr_map   = wr_ctrl | (aw_addr == ODSIP_OFF_STAT) | (aw_addr == ODSIP_OFF_CFG0)
		| (aw_addr == ODSIP_OFF_CFG1) | (aw_addr == ODSIP_OFF_PRE)
		| (aw_addr[7:5] == ODSIP_WIN_LATCH) | (aw_addr[7:5] == ODSIP_WIN_HOLD);
	wire ar_take  = i_axi_arvalid & o_axi_arready;
	wire [2:0] ar_idx = i_axi_araddr[4:2];

	// only the control word is writable; other mapped words ignore writes
	always_comb
	begin
		rd_data = ODSIP_ZERO32;
		rd_err  = 1'b0;
		if (i_axi_araddr == ODSIP_OFF_CTRL)
			rd_data[0] = rx_enable;
		else if (i_axi_araddr == ODSIP_OFF_STAT)
		begin
			rd_data[ODSIP_STAT_MODE] = mode_held;
			rd_data[ODSIP_STAT_LOAD] = load_s;
			rd_data[ODSIP_STAT_PRE]  = preset_s;
			rd_data[ODSIP_STAT_PEND] = pending;
		end
		else if (i_axi_araddr == ODSIP_OFF_CFG0)
			rd_data[ODSIP_DATA_W-1:0] = cfg0;
		else if (i_axi_araddr == ODSIP_OFF_CFG1)
			rd_data[ODSIP_DATA_W-1:0] = cfg1;
		else if (i_axi_araddr == ODSIP_OFF_PRE)
			rd_data[ODSIP_DATA_W-1:0] = preset;
		else if (i_axi_araddr[7:5] == ODSIP_WIN_LATCH && i_axi_araddr[1:0] == 2'h0)
			rd_data[ODSIP_DATA_W-1:0] = o_channel_code[ar_idx];
		else if (i_axi_araddr[7:5] == ODSIP_WIN_HOLD && i_axi_araddr[1:0] == 2'h0)
			rd_data[ODSIP_DATA_W-1:0] = holding[ar_idx];
		else
			rd_err = 1'b1;
	end

	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_axi_awready <= 1'b0;
			o_axi_wready  <= 1'b0;
			o_axi_bvalid  <= 1'b0;
			o_axi_bresp   <= ODSIP_RESP_OKAY;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
			rx_enable     <= 1'b1;
			wr_armed      <= 1'b0;
		end
		else
		begin
			if (aw_take)
			begin
				aw_addr       <= i_axi_awaddr;
				o_axi_awready <= 1'b0;
			end
			if (w_take)
			begin
				w_data       <= i_axi_wdata;
				w_strb       <= i_axi_wstrb;
				o_axi_wready <= 1'b0;
			end
			if (wr_fire)
			begin
				o_axi_bvalid <= 1'b1;
				o_axi_bresp  <= wr_map ? ODSIP_RESP_OKAY : ODSIP_RESP_SLVERR;
				wr_armed     <= 1'b0;
				if (wr_ctrl && w_strb[0])
					rx_enable <= w_data[0];
			end
			else if (o_axi_bvalid && i_axi_bready)
			begin
				o_axi_bvalid  <= 1'b0;
				o_axi_awready <= 1'b1;
				o_axi_wready  <= 1'b1;
				wr_armed      <= 1'b1;
			end
			else if (!wr_armed && !o_axi_bvalid)
			begin
				o_axi_awready <= 1'b1;
				o_axi_wready  <= 1'b1;
				wr_armed      <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_axi_arready <= 1'b0;
			o_axi_rvalid  <= 1'b0;
			o_axi_rdata   <= ODSIP_ZERO32;
			o_axi_rresp   <= ODSIP_RESP_OKAY;
		end
		else if (ar_take)
		begin
			o_axi_arready <= 1'b0;
			o_axi_rvalid  <= 1'b1;
			o_axi_rdata   <= rd_data;
			o_axi_rresp   <= rd_err ? ODSIP_RESP_SLVERR : ODSIP_RESP_OKAY;
		end
		else if (o_axi_rvalid && i_axi_rready)
		begin
			o_axi_rvalid  <= 1'b0;
			o_axi_arready <= 1'b1;
		end
		else if (!o_axi_rvalid)
			o_axi_arready <= 1'b1;
	end

endmodule

// *** verif/odsip_host.sv ***
// Purpose: behavioural host serial master that drives the link pins
// Assumes: 6 ns shift clock, idle low and still between frames
// Notes:   records the chained output 1 ns after each falling edge
module odsip_host (
	// request from bench
	input  wire logic        i_req,
	input  wire logic        i_held,
	input  wire logic [15:0] i_word,
	input  wire logic [4:0]  i_cut,
	input  wire logic [5:0]  i_extra,
	input  wire logic        i_serial_out,
	// link pins
	output logic             o_shift_clock,
	output logic             o_frame_sync,
	output logic             o_serial_in,
	// status to bench
	output logic             o_busy,
	output logic             o_at16,
	output logic [15:0]      o_seen
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		{o_shift_clock, o_serial_in, o_busy, o_at16} = 4'h0;
		o_frame_sync = 1'b1;
		o_seen = 16'h0000;
	end

	// data moves on the rising edge so it is settled well before capture
	task automatic pulse(input logic d);
		o_shift_clock = 1'b1;
		o_serial_in = d;
		#3 o_shift_clock = 1'b0;
		#1 o_seen = {o_seen[14:0], i_serial_out};
		#2;
	endtask

	// ----------------------------------------
	// one frame: three idle edges, then the word
	// ----------------------------------------
	always @(posedge i_req)
	begin
		o_busy = 1'b1;
		repeat (3) pulse(~o_serial_in);
		o_frame_sync = 1'b0;
		for (int k = 15; k >= 0; k--)
		begin
			pulse(i_word[k]);
			if (!i_held && k == 15)
				o_frame_sync = 1'b1;
			if (i_held && int'(i_cut) == 16 - k)
				o_frame_sync = 1'b1;
		end
		if (i_held && i_cut == 5'd0)
		begin
			o_at16 = 1'b1;
			#600 o_at16 = 1'b0;
			o_frame_sync = 1'b1;
		end
		// released data line keeps toggling, never the last bit
		repeat (i_extra) pulse(~o_serial_in);
		o_serial_in = ~o_serial_in;
		o_busy = 1'b0;
	end
endmodule

// *** verif/tb_octal_dac_serial_input_port.sv ***
// Purpose: self-checking bench of the serial input port
// Assumes: host model drives the link, registers read over AXI4-Lite
// Notes:   expected codes are rebuilt from the words the bench sends
module tb_octal_dac_serial_input_port;
	timeunit 1ns;
	timeprecision 100ps;
	import odsip_pkg::*;

	logic        clk, rstn, strap, ldn, pren, req;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic        sclk, fs, sin, sout, busy, at16;
	logic [15:0] word, seen;
	logic [4:0]  cut;
	logic [5:0]  extra;
	odsip_chan_t code, exp;
	int          n_fail, compares, cyc;
	logic [11:0] vals [8] = '{12'hFFF, 12'h001, 12'hA5A, 12'h5A5,
		12'h800, 12'h7FF, 12'h3C3, 12'hC3C};

	odsip_top dut (.i_core_clk(clk), .i_resetn(rstn), .i_shift_clock(sclk), .i_frame_sync(fs),
		.i_serial_in(sin), .o_serial_out(sout), .i_mode_strap(strap), .i_load_outputs_n(ldn),
		.i_preset_n(pren), .o_channel_code(code), .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid),
		.o_axi_awready(awready), .i_axi_wdata(wdata), .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid),
		.o_axi_wready(wready), .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
		.i_axi_araddr(araddr), .i_axi_arvalid(arvalid), .o_axi_arready(arready),
		.o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready));
	odsip_host host (.i_req(req), .i_held(strap), .i_word(word), .i_cut(cut), .i_extra(extra),
		.i_serial_out(sout), .o_shift_clock(sclk), .o_frame_sync(fs), .o_serial_in(sin),
		.o_busy(busy), .o_at16(at16), .o_seen(seen));

	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [95:0] sv, ev);
		compares++;
		if (sv !== ev)
		begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", name, ev, sv);
		end
	endtask

	task automatic print_verdict();
		if (n_fail == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		while (!bvalid)
			@(posedge clk);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge clk);
		while (!arready);
		arvalid <= 1'b0;
		do
			@(posedge clk);
		while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] v, input logic [1:0] rs);
		axi_rd(a);
		check($sformatf("rdata %h", a), 96'(d), 96'(v));
		check($sformatf("rresp %h", a), 96'(r), 96'(rs));
	endtask

	// word, cut point and extra edges settle a cycle before the request
	task automatic send(input logic [15:0] w, input logic [4:0] c, input logic [5:0] x,
		input logic mid);
		@(posedge clk);
		word <= w;
		cut <= c;
		extra <= x;
		@(posedge clk);
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		if (mid)
		begin
			while (!at16)
				@(posedge clk);
			repeat (4) @(posedge clk);
			check("early commit", code, exp);
		end
		while (busy)
			@(posedge clk);
		repeat (8) @(posedge clk);
	endtask

	task automatic do_reset(input logic s);
		rstn <= 1'b0;
		strap <= s;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
		exp = '0;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			print_verdict();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		{word, cut, extra, req, ldn} = '0;
		pren = 1'b1;
		wstrb = 4'hF;
		do_reset(1'b0);
		check("reset codes", code, exp);
		rd_chk(ODSIP_OFF_CTRL, 32'h0000_0001, ODSIP_RESP_OKAY);
		rd_chk(8'h40, ODSIP_ZERO32, ODSIP_RESP_OKAY);
		rd_chk(ODSIP_OFF_STAT, 32'h0000_0004, ODSIP_RESP_OKAY);
		axi_rd(8'h60);
		check("unmapped read", 96'(r), 96'(ODSIP_RESP_SLVERR));
		axi_wr(8'h60, 32'h0000_0001);
		check("unmapped write", 96'(r), 96'(ODSIP_RESP_SLVERR));
		axi_wr(ODSIP_OFF_CTRL, 32'h0000_0001);
		check("ctrl write", 96'(r), 96'(ODSIP_RESP_OKAY));
		for (int i = 0; i < 8; i++)
		begin
			send({i[3:0], vals[i]}, 5'd0, 6'd0, 1'b0);
			exp[i] = vals[i];
		end
		check("direct words", code, exp);
		rd_chk(8'h5C, {20'h0_0000, vals[7]}, ODSIP_RESP_OKAY);
		for (int k = 0; k < 4; k++)
		begin
			send({ODSIP_PAIR_TAG, k[1:0], 12'h1A3 * k[11:0]}, 5'd0, 6'd0, 1'b0);
			exp[2 * k] = 12'h1A3 * k[11:0];
			exp[2 * k + 1] = ~exp[2 * k];
		end
		check("pair words", code, exp);
		// outputs must hold while the load pin is high
		ldn <= 1'b1;
		repeat (4) @(posedge clk);
		send({4'h2, 12'h456}, 5'd0, 6'd0, 1'b0);
		rd_chk(8'h48, 32'h0000_0456, ODSIP_RESP_OKAY);
		check("load high", code, exp);
		ldn <= 1'b0;
		repeat (6) @(posedge clk);
		exp[2] = 12'h456;
		check("load low", code, exp);
		send({ODSIP_A_PRESET, 12'h9C9}, 5'd0, 6'd0, 1'b0);
		pren <= 1'b0;
		repeat (6) @(posedge clk);
		check("preset", code, {8{12'h9C9}});
		pren <= 1'b1;
		repeat (6) @(posedge clk);
		check("preset off", code, exp);
		send({4'h5, 12'h6B1}, 5'd0, 6'd16, 1'b0);
		exp[5] = 12'h6B1;
		check("chain off", 96'(seen), 96'(0));
		check("late edges", code, exp);
		send({ODSIP_A_CTRL0, 12'h008}, 5'd0, 6'd0, 1'b0);
		send({4'h4, 12'hD2E}, 5'd0, 6'd16, 1'b0);
		exp[4] = 12'hD2E;
		check("chain data", 96'(seen), 96'(16'h4D2E));
		check("late edges", code, exp);
		// words stay pending while reception is disabled
		axi_wr(ODSIP_OFF_CTRL, ODSIP_ZERO32);
		send({4'h6, 12'h0F0}, 5'd0, 6'd0, 1'b0);
		rd_chk(ODSIP_OFF_STAT, 32'h0000_000C, ODSIP_RESP_OKAY);
		check("rx disabled", code, exp);
		axi_wr(ODSIP_OFF_CTRL, 32'h0000_0001);
		repeat (6) @(posedge clk);
		exp[6] = 12'h0F0;
		check("rx enabled", code, exp);
		do_reset(1'b1);
		rd_chk(ODSIP_OFF_STAT, 32'h0000_0005, ODSIP_RESP_OKAY);
		send({4'h3, 12'hABC}, 5'd0, 6'd0, 1'b1);
		exp[3] = 12'hABC;
		check("held word", code, exp);
		send({4'h3, 12'h111}, 5'd8, 6'd0, 1'b0);
		check("cut word", code, exp);
		print_verdict();
	end
endmodule
